// >>> logic/mtpw_cfg.svh
// Constants for the timer, prescaler and watchdog block.
// Assumes inclusion by the top module and the bench.
`ifndef MTPW_CFG_SVH
`define MTPW_CFG_SVH
// ==========================================================
// Register map (byte addresses)
`define MTPW_A_PCTRL   12'h000
`define MTPW_A_PRELOAD 12'h004
`define MTPW_A_W1      12'h008
`define MTPW_A_W2      12'h00c
`define MTPW_A_W3      12'h010
`define MTPW_A_W4      12'h014
`define MTPW_A_W5      12'h018
`define MTPW_A_W6      12'h01c
`define MTPW_A_T1      12'h020
`define MTPW_A_T2      12'h024
`define MTPW_A_T3      12'h028
`define MTPW_A_T4      12'h02c
`define MTPW_A_STAT    12'h030
`define MTPW_A_MASK    12'h034
`define MTPW_A_CNT     12'h038
// ==========================================================
// Field positions
`define MTPW_RUN_BIT   0
`define MTPW_T4RUN_BIT 1
`define MTPW_T4SRC_BIT 0
`define MTPW_PWMX_BIT  2
`define MTPW_STAT_WDF  4
// ==========================================================
// Watchdog
`define MTPW_WDOG_RATIO 65534
`endif

// >>> logic/mtpw_pkg.sv
// Types shared by the timer block.
// Assumes the cfg header for constants.
package mtpw_pkg;
    // One timer's control nibble
    typedef struct packed {
        logic       mode3;
        logic       run;
        logic [1:0] src;
    } mtpw_wctl_t;
    // Pin group towards the counter and interrupt pins
    typedef struct packed {
        logic ext_irq_pin_a;
        logic ext_irq_pin_b;
        logic counter_pin_a;
        logic counter_pin_b;
        logic crystal_input;
    } mtpw_pins_t;
endpackage

// >>> logic/mtpw_top.sv
// Timer subsystem: prescaler, four auto-reload timers, watchdog, APB regs.
// Assumes pins synchronous to pclk; clock sources arrive as levels.
//
// Contract
// - Fixed divider flags after n pulses
// - Timer counts n+1, flags, reloads, continues
// - Prescaler 8-bit, instruction clock, ratio 1-256
// - Timer 1 source: instr, prescaler, crystal, pin
// - Timer 1 links int A, feeds timer 2
// - Timer 2 source: sys, prescaler, t1, pwm
// - Timer 3 source: pwm, prescaler, t2, pin B
// - Timer 4 PWM, counts crystal or every second prescaler pulse
// - Each timer has own interrupt flag
// - Control registers govern; watchdog runs free
// - Watchdog 65534, flag then reset on second
// - Prescaler divides by reload plus one
// - Prescaler counts only when run bit set
`include "mtpw_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module mtpw_top
    import mtpw_pkg::*;
#(
    parameter int WDOG_RATIO = `MTPW_WDOG_RATIO
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Count sources and pins
    input  wire logic        instr_cycle_clock,
    input  wire logic        sys_clock_src,
    input  wire mtpw_pins_t  pins,
    // Outputs
    output logic             counter_out_a,
    output logic             counter_out_b,
    output logic             pwm_signal,
    output logic             irq,
    output logic             sys_reset_req
);
    // ==========================================================
    // Edge detection of count sources (sources are levels)
    logic [5:0] src_q;
    wire  [5:0] src_now = {instr_cycle_clock, sys_clock_src, pins.crystal_input,
                           pins.counter_pin_a, pins.counter_pin_b, pwm_signal};
    wire  [5:0] src_rise = src_now & ~src_q;
    wire  e_instr = src_rise[5];
    wire  e_sys   = src_rise[4];
    wire  e_xtal  = src_rise[3];
    wire  e_pina  = src_rise[2];
    wire  e_pinb  = src_rise[1];
    wire  e_pwm   = src_rise[0];
    logic [1:0] irqa_q;
    // Interrupt-pin edges start linked timers
    wire  e_irqa = pins.ext_irq_pin_a & ~irqa_q[0];
    wire  e_irqb = pins.ext_irq_pin_b & ~irqa_q[1];

    // Registers
    logic [3:0] prescaler_control;
    logic [7:0] prescaler_reload, pre_cnt;
    mtpw_wctl_t w1, w2, w3, w5;
    logic [3:0] w4, w6;
    logic [7:0] rel [4];
    logic [7:0] cnt [4];
    logic [4:0] stat, mask;
    logic [15:0] wd_cnt;
    logic       prescaler_out, pwm_div;
    logic [3:0] udf;
    // Bus write strobes, declared early because the counters load from them
    wire        acc    = psel & penable;
    wire        wr     = acc & pwrite;
    wire        wr_pre = wr & (paddr == `MTPW_A_PRELOAD);
    wire [3:0]  wr_tim;
    assign wr_tim[0] = wr & (paddr == `MTPW_A_T1);
    assign wr_tim[1] = wr & (paddr == `MTPW_A_T2);
    assign wr_tim[2] = wr & (paddr == `MTPW_A_T3);
    assign wr_tim[3] = wr & (paddr == `MTPW_A_T4);

    // ==========================================================
    // Shared arithmetic: one step of an auto-reload down counter
    function automatic logic [7:0] step(input logic [7:0] c, input logic [7:0] r);
        step = (c == 8'h00) ? r : c - 8'h01;
    endfunction

    // ==========================================================
    // Prescaler: counts instruction clock edges while run bit set
    wire pre_run  = prescaler_control[`MTPW_RUN_BIT];
    wire pre_tick = pre_run & e_instr;
    wire pre_udf  = pre_tick & (pre_cnt == 8'h00);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt       <= 8'h00;
            prescaler_out <= 1'b0;
        end else begin
            if (wr_pre)
                pre_cnt <= pwdata[7:0];
            else if (pre_tick)
                pre_cnt <= step(pre_cnt, prescaler_reload);
            prescaler_out <= pre_udf;
        end
    end

    // ==========================================================
    // Count-source multiplexers
    wire src1 = (w1.src == 2'h0) ? e_instr :
                (w1.src == 2'h1) ? prescaler_out :
                (w1.src == 2'h2) ? e_xtal : e_pina;
    wire src2 = (w2.src == 2'h0) ? e_sys :
                (w2.src == 2'h1) ? prescaler_out :
                (w2.src == 2'h2) ? udf[0] : e_pwm;
    wire src3 = (w3.src == 2'h0) ? e_pwm :
                (w3.src == 2'h1) ? prescaler_out :
                (w3.src == 2'h2) ? udf[1] : e_pinb;
    wire src4 = w4[`MTPW_T4SRC_BIT] ? (prescaler_out & pwm_div) : e_xtal;

    // Interrupt-linked gating: with mode bit set, wait for pin edge
    logic t1_armed, t3_armed;
    wire  run1 = w1.run & (~w1.mode3 | t1_armed);
    wire  run3 = w3.run & (~w3.mode3 | t3_armed);
    wire  run4 = w4[`MTPW_T4RUN_BIT];
    wire [3:0] tick = {run4 & src4, run3 & src3, w2.run & src2, run1 & src1};
    wire [3:0] next_udf;
    genvar gi;
    for (gi = 0; gi < 4; gi++) begin : g_udf
        assign next_udf[gi] = tick[gi] & (cnt[gi] == 8'h00);
    end

    // ==========================================================
    // Four timers: count down, reload on underflow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) begin
                cnt[i] <= 8'h00;
            end
            udf <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (wr_tim[i])
                    cnt[i] <= pwdata[7:0];
                else if (tick[i])
                    cnt[i] <= step(cnt[i], rel[i]);
            end
            udf <= next_udf;
        end
    end

    // Linked start, pin divide-by-2 outputs and PWM toggle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irqa_q        <= 2'b00;
            src_q         <= 6'h00;
            t1_armed      <= 1'b0;
            t3_armed      <= 1'b0;
            counter_out_a <= 1'b0;
            counter_out_b <= 1'b0;
            pwm_signal    <= 1'b0;
            pwm_div       <= 1'b0;
        end else begin
            irqa_q <= {pins.ext_irq_pin_b, pins.ext_irq_pin_a};
            src_q  <= src_now;
            if (!w1.run)
                t1_armed <= 1'b0;
            else if (e_irqa)
                t1_armed <= 1'b1;
            if (!w3.run)
                t3_armed <= 1'b0;
            else if (e_irqb)
                t3_armed <= 1'b1;
            if (w2.mode3 ? udf[1] : udf[0])
                counter_out_a <= ~counter_out_a;
            if (w6[1] ? udf[2] : udf[3])
                counter_out_b <= ~counter_out_b;
            if (udf[3])
                pwm_signal <= ~pwm_signal;
            if (prescaler_out)
                pwm_div <= ~pwm_div;
        end
    end

    // ==========================================================
    // Watchdog: free running, flag on first expiry, reset on second
    wire wd_exp = e_instr & (wd_cnt == 16'(WDOG_RATIO - 1));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_cnt        <= 16'h0000;
            sys_reset_req <= 1'b0;
        end else begin
            if (e_instr)
                wd_cnt <= wd_exp ? 16'h0000 : wd_cnt + 16'h0001;
            if (wd_exp & stat[`MTPW_STAT_WDF])
                sys_reset_req <= 1'b1;
        end
    end

    // ==========================================================
    // APB decode; zero wait states
    wire        hit   = (paddr <= `MTPW_A_CNT) && (paddr[1:0] == 2'b00);
    wire        wr_stat = wr & (paddr == `MTPW_A_STAT);
    wire [4:0]  ev = {wd_exp, next_udf};
    wire [4:0]  next_stat = ev | (stat & ~(wr_stat ? pwdata[4:0] : 5'h00));

    logic [31:0] rmux;
    always_comb begin
        rmux = 32'h0;
        if (paddr == `MTPW_A_PCTRL)        rmux[3:0] = prescaler_control;
        else if (paddr == `MTPW_A_PRELOAD) rmux[7:0] = prescaler_reload;
        else if (paddr == `MTPW_A_W1)      rmux[3:0] = w1;
        else if (paddr == `MTPW_A_W2)      rmux[3:0] = w2;
        else if (paddr == `MTPW_A_W3)      rmux[3:0] = w3;
        else if (paddr == `MTPW_A_W4)      rmux[3:0] = w4;
        else if (paddr == `MTPW_A_W5)      rmux[3:0] = w5;
        else if (paddr == `MTPW_A_W6)      rmux[3:0] = w6;
        else if (paddr == `MTPW_A_T1)      rmux[7:0] = cnt[0];
        else if (paddr == `MTPW_A_T2)      rmux[7:0] = cnt[1];
        else if (paddr == `MTPW_A_T3)      rmux[7:0] = cnt[2];
        else if (paddr == `MTPW_A_T4)      rmux[7:0] = cnt[3];
        else if (paddr == `MTPW_A_STAT)    rmux[4:0] = stat;
        else if (paddr == `MTPW_A_MASK)    rmux[4:0] = mask;
        else if (paddr == `MTPW_A_CNT)     rmux[15:0] = wd_cnt;
    end

    // Register writes; timer writes load both counter and reload
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescaler_control <= 4'h0;
            prescaler_reload  <= 8'h00;
            w1 <= '0; w2 <= '0; w3 <= '0; w5 <= '0;
            w4 <= 4'h0; w6 <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                rel[i] <= 8'h00;
            end
            mask <= 5'h00;
        end else if (wr) begin
            if (paddr == `MTPW_A_PCTRL)        prescaler_control <= pwdata[3:0];
            else if (paddr == `MTPW_A_PRELOAD) prescaler_reload  <= pwdata[7:0];
            else if (paddr == `MTPW_A_W1)      w1 <= pwdata[3:0];
            else if (paddr == `MTPW_A_W2)      w2 <= pwdata[3:0];
            else if (paddr == `MTPW_A_W3)      w3 <= pwdata[3:0];
            else if (paddr == `MTPW_A_W4)      w4 <= pwdata[3:0];
            else if (paddr == `MTPW_A_W5)      w5 <= pwdata[3:0];
            else if (paddr == `MTPW_A_W6)      w6 <= pwdata[3:0];
            else if (paddr == `MTPW_A_MASK)    mask <= pwdata[4:0];
            for (int i = 0; i < 4; i++) begin
                if (wr_tim[i]) rel[i] <= pwdata[7:0];
            end
        end
    end

    // Status (set wins over clear), bus answer, interrupt line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat    <= 5'h00;
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            irq     <= 1'b0;
        end else begin
            stat    <= next_stat;
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit;
            prdata  <= (psel & ~penable & hit) ? rmux : 32'h0;
            irq     <= |(next_stat & mask);
        end
    end

    // ==========================================================
    // Assertions
    property p_pre_gate;
        @(posedge pclk) disable iff (!presetn)
        !pre_run |=> !prescaler_out;
    endproperty
    a_pre_gate: assert property (p_pre_gate) else $error("prescaler ran while stopped");
    property p_udf_pulse;
        @(posedge pclk) disable iff (!presetn)
        udf[0] |=> !udf[0];
    endproperty
    a_udf_pulse: assert property (p_udf_pulse) else $error("underflow not one cycle");
    property p_reload;
        @(posedge pclk) disable iff (!presetn)
        (next_udf[1] && !wr_tim[1]) |=> cnt[1] == $past(rel[1]);
    endproperty
    a_reload: assert property (p_reload) else $error("timer 2 did not reload");
    property p_flag;
        @(posedge pclk) disable iff (!presetn)
        next_udf[2] |=> stat[2];
    endproperty
    a_flag: assert property (p_flag) else $error("timer 3 flag not set");
    property p_pre_reload;
        @(posedge pclk) disable iff (!presetn)
        (pre_udf && !wr_pre) |=> pre_cnt == $past(prescaler_reload);
    endproperty
    a_pre_reload: assert property (p_pre_reload) else $error("prescaler reload wrong");
    property p_wdf;
        @(posedge pclk) disable iff (!presetn)
        wd_exp |=> stat[`MTPW_STAT_WDF];
    endproperty
    a_wdf: assert property (p_wdf) else $error("watchdog flag not set");
    property p_chain;
        @(posedge pclk) disable iff (!presetn)
        (w2.src == 2'h2 && w2.run && udf[0]) |-> tick[1];
    endproperty
    a_chain: assert property (p_chain) else $error("timer 1 underflow not counted");
    property p_t1_link;
        @(posedge pclk) disable iff (!presetn)
        (w1.mode3 && !t1_armed) |-> !tick[0];
    endproperty
    a_t1_link: assert property (p_t1_link) else $error("timer 1 ran before start edge");
    property p_t3_link;
        @(posedge pclk) disable iff (!presetn)
        (w3.mode3 && !t3_armed) |-> !tick[2];
    endproperty
    a_t3_link: assert property (p_t3_link) else $error("timer 3 ran before start edge");
    property p_pre_hold;
        @(posedge pclk) disable iff (!presetn)
        (!pre_tick && !wr_pre) |=> $stable(pre_cnt);
    endproperty
    a_pre_hold: assert property (p_pre_hold) else $error("prescaler moved while idle");
    property p_t1_hold;
        @(posedge pclk) disable iff (!presetn)
        (!tick[0] && !wr_tim[0]) |=> $stable(cnt[0]);
    endproperty
    a_t1_hold: assert property (p_t1_hold) else $error("timer 1 moved without a count");
    property p_t4_flag;
        @(posedge pclk) disable iff (!presetn)
        next_udf[3] |=> stat[3];
    endproperty
    a_t4_flag: assert property (p_t4_flag) else $error("timer 4 flag not set");
    property p_wd_reset;
        @(posedge pclk) disable iff (!presetn)
        (wd_exp && stat[`MTPW_STAT_WDF]) |=> sys_reset_req;
    endproperty
    a_wd_reset: assert property (p_wd_reset) else $error("no reset on second expiry");
    c_link: cover property (@(posedge pclk) disable iff (!presetn) $rose(t1_armed));
    c_udf4: cover property (@(posedge pclk) disable iff (!presetn) udf[3]);
    c_reset: cover property (@(posedge pclk) disable iff (!presetn) $rose(sys_reset_req));
    c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
endmodule
`default_nettype wire

// >>> test/mtpw_far_model.sv
// Far-side model: count sources, counter pins and interrupt pins.
// Assumes the bench calls pulse() from its main sequence.
`timescale 1ns/1ps
`default_nettype none
module mtpw_far_model
    import mtpw_pkg::*;
(
    // Clock
    input  wire logic  pclk,
    // Sources towards the block
    output logic       instr_cycle_clock,
    output logic       sys_clock_src,
    output mtpw_pins_t pins
);
    // ==========================================================
    // Levels: 0 instr, 1 sys, 2 crystal, 3 pin a, 4 pin b, 5/6 irq pins
    logic [6:0] lv = 7'h00;
    assign instr_cycle_clock = lv[0];
    assign sys_clock_src     = lv[1];
    assign pins              = {lv[5], lv[6], lv[3], lv[4], lv[2]};
    // Wide pulses so the pclk edge detector sees each rise exactly once
    task automatic pulse(input int src, input int k);
        for (int i = 0; i < k; i++) begin
            @(posedge pclk);
            lv[src] <= 1'b1;
            repeat (2) @(posedge pclk);
            lv[src] <= 1'b0;
            repeat (3) @(posedge pclk);
        end
    endtask
endmodule
`default_nettype wire

// >>> test/test_mcu_timer_prescaler_watchdog.sv
// Bench for the timer block: APB tasks, source pulses, status checks.
// Assumes the far-side model and a watchdog ratio shortened to 8.
`include "mtpw_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module test_mcu_timer_prescaler_watchdog;
    import mtpw_pkg::*;
    // ==========================================================
    // Signals
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, c_a, c_b, pwm, irq, sys_rst;
    logic        instr, sysck;
    mtpw_pins_t  pins;
    logic [31:0] rd;
    logic        rerr;
    int          err_total  = 0;
    int          n_compared = 0;
    // Timer table: control reg, control value, count reg, source, status bit
    logic [11:0] wa [6] = '{`MTPW_A_W1, `MTPW_A_W1, `MTPW_A_W1,
                            `MTPW_A_W2, `MTPW_A_W3, `MTPW_A_W4};
    logic [3:0]  wv [6] = '{4'h4, 4'h6, 4'h7, 4'h4, 4'h7, 4'h2};
    logic [11:0] ta [6] = '{`MTPW_A_T1, `MTPW_A_T1, `MTPW_A_T1,
                            `MTPW_A_T2, `MTPW_A_T3, `MTPW_A_T4};
    int          sr [6] = '{0, 2, 3, 1, 4, 2};
    int          sb [6] = '{0, 0, 0, 1, 2, 3};
    initial forever #5 pclk = ~pclk;
    // ==========================================================
    // Design and far side
    mtpw_top #(.WDOG_RATIO(8)) mtpw_top_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .instr_cycle_clock(instr),
        .sys_clock_src(sysck), .pins(pins), .counter_out_a(c_a),
        .counter_out_b(c_b), .pwm_signal(pwm), .irq(irq),
        .sys_reset_req(sys_rst));
    mtpw_far_model mtpw_far_model_i (.pclk(pclk), .instr_cycle_clock(instr),
        .sys_clock_src(sysck), .pins(pins));
    // ==========================================================
    // Tasks
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; the wait for pready is bounded
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd      = prdata;
        rerr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // A slave that never answers ends the run as a failure
        if (pready !== 1'b1) begin
            err_total++;
            close_out();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask
    // Registered irq needs an edge or two after the write lands
    task automatic irqc(input logic e);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, {31'h0, e});
    endtask
    // ==========================================================
    // Watchdog on the whole run
    initial begin
        repeat (100000) @(posedge pclk);
        err_total++;
        close_out();
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`MTPW_A_STAT, 32'h0, 32'h1f);
        rdc(`MTPW_A_PCTRL, 32'h0, 32'hffffffff);
        apb(1'b0, 12'h03c, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        chk(rd, 32'h0);
        $display("test reset done");
        // Every timer on instr, sys, crystal or pin sources: n=1 flags after two counts, reloads
        for (int i = 0; i < 6; i++) begin
            wr(ta[i], 32'h1);
            wr(wa[i], {28'h0, wv[i]});
            mtpw_far_model_i.pulse(sr[i], 1);
            rdc(`MTPW_A_STAT, 32'h0, 32'hf);
            mtpw_far_model_i.pulse(sr[i], 1);
            rdc(`MTPW_A_STAT, 32'h1 << sb[i], 32'hf);
            rdc(ta[i], 32'h1, 32'hff);
            wr(`MTPW_A_MASK, 32'h1 << sb[i]);
            irqc(1'b1);
            wr(`MTPW_A_STAT, 32'hf);
            irqc(1'b0);
            wr(`MTPW_A_MASK, 32'h0);
            wr(wa[i], 32'h0);
        end
        chk({31'h0, c_a}, 32'h1);
        chk({31'h0, c_b}, 32'h1);
        chk({31'h0, pwm}, 32'h1);
        $display("test sources done");
        // Timer 2 counts timer 1 underflows, once each; pin A follows timer 2
        wr(`MTPW_A_T1, 32'h0);
        wr(`MTPW_A_T2, 32'h1);
        wr(`MTPW_A_W2, 32'he);
        wr(`MTPW_A_W1, 32'h4);
        mtpw_far_model_i.pulse(0, 1);
        rdc(`MTPW_A_STAT, 32'h1, 32'hf);
        wr(`MTPW_A_STAT, 32'hf);
        mtpw_far_model_i.pulse(0, 1);
        rdc(`MTPW_A_STAT, 32'h3, 32'hf);
        chk({31'h0, c_a}, 32'h0);
        wr(`MTPW_A_W1, 32'h0);
        wr(`MTPW_A_W2, 32'h0);
        wr(`MTPW_A_STAT, 32'hf);
        $display("test chain done");
        // Linked starts: no count until the interrupt pin edge
        wr(`MTPW_A_T1, 32'h0);
        wr(`MTPW_A_W1, 32'hc);
        mtpw_far_model_i.pulse(0, 1);
        rdc(`MTPW_A_STAT, 32'h0, 32'hf);
        mtpw_far_model_i.pulse(5, 1);
        mtpw_far_model_i.pulse(0, 1);
        rdc(`MTPW_A_STAT, 32'h1, 32'hf);
        wr(`MTPW_A_W1, 32'h0);
        wr(`MTPW_A_W6, 32'h2);
        wr(`MTPW_A_T3, 32'h0);
        wr(`MTPW_A_W3, 32'hf);
        mtpw_far_model_i.pulse(4, 1);
        rdc(`MTPW_A_STAT, 32'h1, 32'hf);
        mtpw_far_model_i.pulse(6, 1);
        mtpw_far_model_i.pulse(4, 1);
        rdc(`MTPW_A_STAT, 32'h5, 32'hf);
        chk({31'h0, c_b}, 32'h0);
        wr(`MTPW_A_W3, 32'h0);
        wr(`MTPW_A_W6, 32'h0);
        wr(`MTPW_A_STAT, 32'hf);
        $display("test link done");
        // Prescaler: reload first, idle until run, then divide by n+1
        wr(`MTPW_A_PRELOAD, 32'h1);
        wr(`MTPW_A_T1, 32'h0);
        wr(`MTPW_A_W1, 32'h5);
        wr(`MTPW_A_T4, 32'h0);
        wr(`MTPW_A_W4, 32'h3);
        mtpw_far_model_i.pulse(0, 3);
        rdc(`MTPW_A_STAT, 32'h0, 32'hf);
        wr(`MTPW_A_PCTRL, 32'h1);
        mtpw_far_model_i.pulse(0, 1);
        rdc(`MTPW_A_STAT, 32'h0, 32'hf);
        mtpw_far_model_i.pulse(0, 1);
        rdc(`MTPW_A_STAT, 32'h1, 32'hf);
        mtpw_far_model_i.pulse(0, 2);
        rdc(`MTPW_A_STAT, 32'h9, 32'hf);
        chk({31'h0, pwm}, 32'h0);
        chk({31'h0, c_b}, 32'h1);
        $display("test prescaler done");
        // Watchdog from a fresh reset: flag after 8, reset on second expiry
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        mtpw_far_model_i.pulse(0, 7);
        rdc(`MTPW_A_STAT, 32'h0, 32'h10);
        mtpw_far_model_i.pulse(0, 1);
        rdc(`MTPW_A_STAT, 32'h10, 32'h10);
        chk({31'h0, sys_rst}, 32'h0);
        mtpw_far_model_i.pulse(0, 8);
        chk({31'h0, sys_rst}, 32'h1);
        $display("test watchdog done");
        close_out();
    end
endmodule
`default_nettype wire
